// ===== common/asrc_pkg.sv
// Purpose: Constants for the host controller of a 256K x 4 asynchronous static memory
// Assumes: 250 MHz clock, 4 ns period
// Notes: Pin timing counts derive from nanosecond figures
package asrc_pkg;
  localparam int ADDR_W = 18;
  localparam int DATA_W = 4;
  localparam int WORDS = 262144;
  localparam int CLK_PERIOD_NS = 4;
  // Read cycle time, least, in ns
  localparam int READ_CYCLE_TIME_NS = 25;
  localparam int READ_CYCLE_CYC = (READ_CYCLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Write pulse width, least, in ns
  localparam int WRITE_PULSE_NS = 15;
  localparam int WRITE_PULSE_CYC = (WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Deselect to retention, least, in ns
  localparam int DESELECT_TO_RETENTION_TIME_NS = 0;
  localparam int DESELECT_TO_RETENTION_CYC = (DESELECT_TO_RETENTION_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS
    > 0 ? (DESELECT_TO_RETENTION_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS : 1;
  // Retention recovery equals one read cycle time
  localparam int RETENTION_RECOVERY_TIME_NS = READ_CYCLE_TIME_NS;
  localparam int RETENTION_RECOVERY_CYC = (RETENTION_RECOVERY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 4;
  localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
  typedef enum logic [1:0] {ASRC_OP_READ, ASRC_OP_WRITE, ASRC_OP_SLEEP, ASRC_OP_WAKE} asrc_op_t;
endpackage

// ===== core/asrc_timer.sv
// Purpose: Down counter that times each phase of a memory cycle
// Assumes: load and count share one clock
// Notes: done_out is high while the count stands at zero
`timescale 1ns/1ns
module asrc_timer (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic load_in,
  input wire logic [asrc_pkg::CNT_W-1:0] value_in,
  output logic done_out
);
  import asrc_pkg::*;
  logic [CNT_W-1:0] cnt_r;
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cnt_r <= CNT_ZERO;
    end else if (load_in) begin
      cnt_r <= value_in;
    end else if (cnt_r != CNT_ZERO) begin
      cnt_r <= cnt_r - 4'h1;
    end
  end
  assign done_out = (cnt_r == CNT_ZERO);
endmodule // asrc_timer

// ===== core/asrc_host.sv
// Purpose: Host controller that runs read, write and retention cycles on a 256K x 4 static memory
// Assumes: memory pins sampled synchronously to clk_in
// Notes: One request at a time; req_ready_out high when idle
`timescale 1ns/1ns
// Function
// - The host holds the strobe low for writes and high through every read.
// - A write starts when the later control falls and ends when the first one rises.
// - The host sets the address no later than the last select or drive enable falls.
// - The host deselects before entering retention, at least zero time before.
// - After retention the host waits one read cycle time before any cycle.
module asrc_host (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic req_valid_in,
  input wire asrc_pkg::asrc_op_t req_op_in,
  input wire logic [asrc_pkg::ADDR_W-1:0] req_addr_in,
  input wire logic [asrc_pkg::DATA_W-1:0] req_wdata_in,
  output logic req_ready_out,
  output logic rsp_valid_out,
  output logic [asrc_pkg::DATA_W-1:0] rsp_rdata_out,
  output logic retention_out,
  output logic [asrc_pkg::ADDR_W-1:0] cell_select_lines_out,
  output logic select_n_out,
  output logic write_strobe_n_out,
  output logic drive_enable_n_out,
  input wire logic [asrc_pkg::DATA_W-1:0] data_lines_in,
  output logic [asrc_pkg::DATA_W-1:0] data_lines_out,
  output logic data_lines_oe_n_out
);
  import asrc_pkg::*;
  typedef enum logic [2:0] {ASRC_IDLE, ASRC_RD, ASRC_WR, ASRC_WR_END, ASRC_SLEEP, ASRC_RECOVER} asrc_state_t;
  asrc_state_t state_r;
  logic tmr_load;
  logic [CNT_W-1:0] tmr_value;
  logic tmr_done;
  logic accept;

  assign accept = req_valid_in && req_ready_out;

  asrc_timer u_timer (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .load_in(tmr_load),
    .value_in(tmr_value),
    .done_out(tmr_done)
  );

  always_comb begin
    tmr_load = 1'b0;
    tmr_value = CNT_ZERO;
    if (accept && req_op_in == ASRC_OP_READ) begin
      tmr_load = 1'b1;
      tmr_value = CNT_W'(READ_CYCLE_CYC - 1);
    end else if (accept && req_op_in == ASRC_OP_WRITE) begin
      tmr_load = 1'b1;
      tmr_value = CNT_W'(WRITE_PULSE_CYC - 1);
    end else if (accept && req_op_in == ASRC_OP_SLEEP) begin
      tmr_load = 1'b1;
      tmr_value = CNT_W'(DESELECT_TO_RETENTION_CYC - 1);
    end else if (state_r == ASRC_SLEEP && retention_out && req_valid_in && req_op_in == ASRC_OP_WAKE) begin
      tmr_load = 1'b1;
      tmr_value = CNT_W'(RETENTION_RECOVERY_CYC - 1);
    end
  end

  // Sequencer
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_r <= ASRC_IDLE;
    end else begin
      unique case (state_r)
        ASRC_IDLE: begin
          if (accept) begin
            unique case (req_op_in)
              ASRC_OP_READ: state_r <= ASRC_RD;
              ASRC_OP_WRITE: state_r <= ASRC_WR;
              ASRC_OP_SLEEP: state_r <= ASRC_SLEEP;
              ASRC_OP_WAKE: state_r <= ASRC_IDLE;
            endcase
          end
        end
        ASRC_RD: if (tmr_done) state_r <= ASRC_IDLE;
        ASRC_WR: if (tmr_done) state_r <= ASRC_WR_END;
        ASRC_WR_END: state_r <= ASRC_IDLE;
        ASRC_SLEEP: if (tmr_load) state_r <= ASRC_RECOVER;
        ASRC_RECOVER: if (tmr_done) state_r <= ASRC_IDLE;
      endcase
    end
  end

  // Request handshake
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      req_ready_out <= 1'b0;
    end else begin
      req_ready_out <= (state_r == ASRC_IDLE && !accept) || (state_r == ASRC_RD && tmr_done)
        || state_r == ASRC_WR_END || (state_r == ASRC_RECOVER && tmr_done);
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cell_select_lines_out <= '0;
    end else if (accept && (req_op_in == ASRC_OP_READ || req_op_in == ASRC_OP_WRITE)) begin
      cell_select_lines_out <= req_addr_in;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      select_n_out <= 1'b1;
      write_strobe_n_out <= 1'b1;
      drive_enable_n_out <= 1'b1;
    end else begin
      select_n_out <= !(accept && (req_op_in == ASRC_OP_READ || req_op_in == ASRC_OP_WRITE))
        && !(state_r == ASRC_RD && !tmr_done) && !(state_r == ASRC_WR && !tmr_done);
      write_strobe_n_out <= !(accept && req_op_in == ASRC_OP_WRITE) && !(state_r == ASRC_WR && !tmr_done);
      drive_enable_n_out <= !(accept && req_op_in == ASRC_OP_READ) && !(state_r == ASRC_RD && !tmr_done);
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      data_lines_out <= '0;
      data_lines_oe_n_out <= 1'b1;
    end else if (accept && req_op_in == ASRC_OP_WRITE) begin
      data_lines_out <= req_wdata_in;
      data_lines_oe_n_out <= 1'b0;
    end else if (state_r == ASRC_WR_END || state_r == ASRC_IDLE) begin
      data_lines_oe_n_out <= 1'b1;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rsp_valid_out <= 1'b0;
      rsp_rdata_out <= '0;
    end else begin
      rsp_valid_out <= (state_r == ASRC_RD && tmr_done);
      if (state_r == ASRC_RD && tmr_done) begin
        rsp_rdata_out <= data_lines_in;
      end
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      retention_out <= 1'b0;
    end else if (state_r == ASRC_SLEEP && tmr_done) begin
      retention_out <= 1'b1;
    end else if (state_r == ASRC_RECOVER) begin
      retention_out <= 1'b0;
    end
  end

  a_strobe_read_high: assert property (@(posedge clk_in) disable iff (rst_in)
    !drive_enable_n_out |-> write_strobe_n_out) else $error("strobe low during read");
  a_bus_contention: assert property (@(posedge clk_in) disable iff (rst_in)
    !drive_enable_n_out |-> data_lines_oe_n_out) else $error("host drives during read");
  a_data_hold_close: assert property (@(posedge clk_in) disable iff (rst_in)
    $rose(write_strobe_n_out) |-> !data_lines_oe_n_out && $stable(data_lines_out)) else $error("data not held");
  a_write_window: assert property (@(posedge clk_in) disable iff (rst_in)
    $fell(write_strobe_n_out) |-> !select_n_out [*4]) else $error("write window short");
  a_addr_stable: assert property (@(posedge clk_in) disable iff (rst_in)
    !select_n_out && $past(!select_n_out) |-> $stable(cell_select_lines_out)) else $error("address moved");
  a_sleep_deselect: assert property (@(posedge clk_in) disable iff (rst_in)
    retention_out |-> select_n_out) else $error("selected in retention");
  a_wake_recover: assert property (@(posedge clk_in) disable iff (rst_in)
    $fell(retention_out) |-> req_ready_out == 1'b0 [*6]) else $error("recovery too short");
  a_read_length: assert property (@(posedge clk_in) disable iff (rst_in)
    $fell(drive_enable_n_out) |-> !drive_enable_n_out [*7] ##1 drive_enable_n_out) else $error("read length");
  c_read: cover property (@(posedge clk_in) rsp_valid_out);
  c_write: cover property (@(posedge clk_in) $rose(write_strobe_n_out));
  c_retention: cover property (@(posedge clk_in) $fell(retention_out));
endmodule // asrc_host

// ===== verif/asrc_mem_model.sv
// Purpose: Behavioural 256K x 4 static memory facing the host
// Assumes: Host pins change only after clock edges
// Notes: An undriven bus shows the inverse of the addressed word
`timescale 1ns/1ns
module asrc_mem_model (
  input wire logic [asrc_pkg::ADDR_W-1:0] cell_select_lines_in,
  input wire logic select_n_in,
  input wire logic write_strobe_n_in,
  input wire logic drive_enable_n_in,
  input wire logic [asrc_pkg::DATA_W-1:0] host_data_in,
  input wire logic host_oe_n_in,
  output logic [asrc_pkg::DATA_W-1:0] data_lines_out
);
  import asrc_pkg::*;
  logic [DATA_W-1:0] mem [WORDS];
  logic [DATA_W-1:0] word;
  logic drive;
  assign word = mem[cell_select_lines_in];
  assign drive = !select_n_in && write_strobe_n_in && !drive_enable_n_in;
  assign data_lines_out = !host_oe_n_in ? host_data_in : (drive ? word : ~word);
  always @(posedge (select_n_in | write_strobe_n_in)) begin
    if (!host_oe_n_in) begin
      mem[cell_select_lines_in] = host_data_in;
    end
  end
endmodule // asrc_mem_model

// ===== verif/asrc_host_tb.sv
// Purpose: Self-checking bench for the static memory host
// Assumes: Inputs change at falling edges
// Notes: Memory model stands on the pins
`timescale 1ns/1ns
module asrc_host_tb;
  import asrc_pkg::*;
  logic clk_in, rst_in, req_valid_in, req_ready_out, rsp_valid_out, retention_out;
  logic select_n_out, write_strobe_n_out, drive_enable_n_out, data_lines_oe_n_out;
  asrc_op_t req_op_in;
  logic [17:0] req_addr_in, cell_select_lines_out;
  logic [3:0] req_wdata_in, rsp_rdata_out, data_lines_in, data_lines_out;
  int n_fail, comparisons, cycles;
  asrc_host asrc_host_inst (.clk_in(clk_in), .rst_in(rst_in), .req_valid_in(req_valid_in),
    .req_op_in(req_op_in), .req_addr_in(req_addr_in), .req_wdata_in(req_wdata_in),
    .req_ready_out(req_ready_out), .rsp_valid_out(rsp_valid_out), .rsp_rdata_out(rsp_rdata_out),
    .retention_out(retention_out), .cell_select_lines_out(cell_select_lines_out),
    .select_n_out(select_n_out), .write_strobe_n_out(write_strobe_n_out),
    .drive_enable_n_out(drive_enable_n_out), .data_lines_in(data_lines_in),
    .data_lines_out(data_lines_out), .data_lines_oe_n_out(data_lines_oe_n_out));
  asrc_mem_model asrc_mem_model_inst (.cell_select_lines_in(cell_select_lines_out),
    .select_n_in(select_n_out), .write_strobe_n_in(write_strobe_n_out),
    .drive_enable_n_in(drive_enable_n_out), .host_data_in(data_lines_out),
    .host_oe_n_in(data_lines_oe_n_out), .data_lines_out(data_lines_in));
  initial begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end
  task automatic stop_test;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 2000) begin
      n_fail++;
      stop_test();
    end
  end
  task automatic chk(input string what, input logic [17:0] exp, input logic [17:0] got);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic issue(input asrc_op_t op, input logic [17:0] a, input logic [3:0] d);
    int n;
    n = 0;
    @(negedge clk_in);
    while (req_ready_out !== 1'b1 && n < 20) begin
      n++;
      @(negedge clk_in);
    end
    req_op_in = op;
    req_addr_in = a;
    req_wdata_in = d;
    req_valid_in = 1'b1;
    @(negedge clk_in);
    req_valid_in = 1'b0;
  endtask
  task automatic do_write(input logic [17:0] a, input logic [3:0] d);
    int n;
    n = 0;
    issue(ASRC_OP_WRITE, a, d);
    while (req_ready_out !== 1'b1 && n < 20) begin
      if (!select_n_out && !write_strobe_n_out) begin
        chk("wr addr", a, cell_select_lines_out);
        chk("wr oe_n", 18'h0, {17'h0, data_lines_oe_n_out});
        chk("wr de_n", 18'h1, {17'h0, drive_enable_n_out});
        chk("wr data", {14'h0, d}, {14'h0, data_lines_out});
      end
      n++;
      @(negedge clk_in);
    end
    chk("wr ready", 18'h1, {17'h0, req_ready_out});
    $display("write test done %h", a);
  endtask
  task automatic do_read(input logic [17:0] a, input logic [3:0] d);
    int n;
    n = 0;
    issue(ASRC_OP_READ, a, 4'h0);
    while (rsp_valid_out !== 1'b1 && n < 20) begin
      chk("rd strobe", 18'h1, {17'h0, write_strobe_n_out});
      if (!select_n_out) begin
        chk("rd addr", a, cell_select_lines_out);
        chk("rd oe_n", 18'h1, {17'h0, data_lines_oe_n_out});
        chk("rd de_n", 18'h0, {17'h0, drive_enable_n_out});
      end
      n++;
      @(negedge clk_in);
    end
    chk("rd valid", 18'h1, {17'h0, rsp_valid_out});
    chk("rd data", {14'h0, d}, {14'h0, rsp_rdata_out});
    $display("read test done %h", a);
  endtask
  task automatic sleep_wake;
    int n;
    n = 0;
    issue(ASRC_OP_SLEEP, 18'h0, 4'h0);
    while (retention_out !== 1'b1 && n < 20) begin
      n++;
      @(negedge clk_in);
    end
    chk("sleep ret", 18'h1, {17'h0, retention_out});
    chk("sleep sel", 18'h1, {17'h0, select_n_out});
    // Read offered in retention is ignored
    req_op_in = ASRC_OP_READ;
    req_valid_in = 1'b1;
    @(negedge clk_in);
    req_valid_in = 1'b0;
    @(negedge clk_in);
    chk("sleep rd sel", 18'h1, {17'h0, select_n_out});
    chk("sleep rd ret", 18'h1, {17'h0, retention_out});
    // Wake is taken in retention without ready
    req_op_in = ASRC_OP_WAKE;
    req_valid_in = 1'b1;
    @(negedge clk_in);
    req_valid_in = 1'b0;
    n = 0;
    while (req_ready_out !== 1'b1 && n < 20) begin
      chk("wake sel", 18'h1, {17'h0, select_n_out});
      n++;
      @(negedge clk_in);
    end
    chk("wake wait", 18'h1, {17'h0, n >= READ_CYCLE_CYC - 1});
    chk("wake ready", 18'h1, {17'h0, req_ready_out});
    chk("wake ret", 18'h0, {17'h0, retention_out});
    $display("retention test done");
  endtask
  initial begin
    rst_in = 1'b1;
    req_valid_in = 1'b0;
    req_op_in = ASRC_OP_READ;
    req_addr_in = 18'h0;
    req_wdata_in = 4'h0;
    repeat (8) @(negedge clk_in);
    rst_in = 1'b0;
    chk("rst sel", 18'h1, {17'h0, select_n_out});
    do_write(18'h00000, 4'ha);
    do_write(18'h3ffff, 4'h5);
    do_write(18'h20000, 4'h3);
    do_read(18'h00000, 4'ha);
    do_read(18'h3ffff, 4'h5);
    do_read(18'h20000, 4'h3);
    do_write(18'h00000, 4'hf);
    do_read(18'h00000, 4'hf);
    sleep_wake();
    do_read(18'h3ffff, 4'h5);
    stop_test();
  end
endmodule // asrc_host_tb
